//--- hdl/sdei_pkg.sv
// Purpose: constants for the switch drop event interrupt block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   printed offsets are register indices; byte address is index times four
package sdei_pkg;
    localparam logic [15:0] MASK_IDX        = 16'h1c20;
    localparam logic [15:0] PEND_IDX        = 16'h1c21;
    localparam logic [17:0] MASK_ADDR       = {MASK_IDX, 2'b00};
    localparam logic [17:0] PEND_ADDR       = {PEND_IDX, 2'b00};
    localparam int          ADDR_W          = 18;
    localparam int          MASK_BIT        = 0;
    localparam logic        MASK_RESET      = 1'b1;
    localparam int          A_VALID_BIT     = 0;
    localparam int          A_PORT_LSB      = 1;
    localparam int          A_REASON_LSB    = 3;
    localparam int          B_VALID_BIT     = 7;
    localparam int          B_PORT_LSB      = 8;
    localparam int          B_REASON_LSB    = 10;
    localparam logic [1:0]  PORT_RESET      = 2'h0;
    localparam logic [1:0]  PORT_RESERVED   = 2'h3;
    localparam logic [3:0]  REASON_RESET    = 4'h0;
    localparam logic [3:0]  RSN_BCAST_LEVEL = 4'h0;
    localparam logic [3:0]  RSN_RED         = 4'h1;
    localparam logic [3:0]  RSN_NO_BUFFER   = 4'h2;
    localparam logic [3:0]  RSN_NO_DESC     = 4'h3;
    localparam logic [3:0]  RSN_NO_DEST     = 4'h4;
    localparam logic [3:0]  RSN_RX_ERROR    = 4'h5;
    localparam logic [3:0]  RSN_DROP_LEVEL  = 4'h6;
    localparam logic [3:0]  RSN_YELLOW      = 4'h9;
endpackage

//--- hdl/sdei_top.sv
// Purpose: drop event status capture, mask and interrupt with APB registers
// Assumes: drop indications are synchronous to CORE_CLK, one pulse per dropped packet
// Notes:   pending register clears on an APB read; events beyond two are lost
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module sdei_top (
    input  wire logic        CORE_CLK,      // core clock, 10 MHz
    input  wire logic        RST,           // synchronous reset, active high
    input  wire logic        PSEL,          // apb select
    input  wire logic        PENABLE,       // apb access phase
    input  wire logic        PWRITE,        // apb direction
    input  wire logic [17:0] PADDR,         // apb byte address
    input  wire logic [31:0] PWDATA,        // apb write data
    output logic      [31:0] PRDATA,        // apb read data
    output logic             PREADY,        // apb ready
    output logic             PSLVERR,       // apb error on unmapped address
    input  wire logic        DROP_VALID,    // one-cycle drop indication
    input  wire logic [1:0]  DROP_PORT,     // source port of dropped packet
    input  wire logic        DROP_BCAST_LVL,// unknown/bcast over broadcast level
    input  wire logic        DROP_RED,      // red drop enabled and metered red
    input  wire logic        DROP_NO_BUF,   // no packet buffers
    input  wire logic        DROP_NO_DESC,  // no memory descriptors
    input  wire logic        DROP_NO_DEST,  // unknown/bcast with no destinations
    input  wire logic        DROP_RX_ERR,   // receive error on packet over 64 bytes
    input  wire logic        DROP_LEVEL,    // buffer drop level exceeded
    input  wire logic        DROP_YELLOW,   // yellow drop random discard
    output logic             IRQ            // level interrupt request
);

    //------------------------------------------------------------
    // apb decode
    //------------------------------------------------------------
    logic mask_q;
    logic a_valid_q;
    logic [1:0] a_port_q;
    logic [3:0] a_reason_q;
    logic b_valid_q;
    logic [1:0] b_port_q;
    logic [3:0] b_reason_q;
    logic access;
    logic hit_mask;
    logic hit_pend;
    logic pend_read;
    logic [31:0] rdata_d;

    assign access    = PSEL && PENABLE;
    assign hit_mask  = (PADDR == sdei_pkg::MASK_ADDR);
    assign hit_pend  = (PADDR == sdei_pkg::PEND_ADDR);
    assign pend_read = access && !PWRITE && hit_pend;
    // zero wait states keeps clear-on-read tied to the single completing edge
    assign PREADY    = 1'b1;
    assign PSLVERR   = access && !(hit_mask || hit_pend);

    always_comb begin
        rdata_d = 32'h0;
        if (hit_mask) begin
            rdata_d[sdei_pkg::MASK_BIT] = mask_q;
        end else if (hit_pend) begin
            rdata_d[sdei_pkg::A_VALID_BIT] = a_valid_q;
            rdata_d[sdei_pkg::A_PORT_LSB +: 2] = a_port_q;
            rdata_d[sdei_pkg::A_REASON_LSB +: 4] = a_reason_q;
            rdata_d[sdei_pkg::B_VALID_BIT] = b_valid_q;
            rdata_d[sdei_pkg::B_PORT_LSB +: 2] = b_port_q;
            rdata_d[sdei_pkg::B_REASON_LSB +: 4] = b_reason_q;
        end
    end

    // data output from flip-flops; captured during setup so it is valid in access
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rdata_d;
        end
    end

    //------------------------------------------------------------
    // mask register
    //------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mask_q <= sdei_pkg::MASK_RESET;
        end else if (access && PWRITE && hit_mask) begin
            mask_q <= PWDATA[sdei_pkg::MASK_BIT];
        end
    end

    //------------------------------------------------------------
    // reason encoding
    //------------------------------------------------------------
    logic [3:0] reason;
    logic       reason_ok;

    // fixed priority when several causes are flagged at once
    always_comb begin
        reason_ok = 1'b1;
        reason    = sdei_pkg::RSN_BCAST_LEVEL;
        if (DROP_BCAST_LVL) begin
            reason = sdei_pkg::RSN_BCAST_LEVEL;
        end else if (DROP_RED) begin
            reason = sdei_pkg::RSN_RED;
        end else if (DROP_NO_BUF) begin
            reason = sdei_pkg::RSN_NO_BUFFER;
        end else if (DROP_NO_DESC) begin
            reason = sdei_pkg::RSN_NO_DESC;
        end else if (DROP_NO_DEST) begin
            reason = sdei_pkg::RSN_NO_DEST;
        end else if (DROP_RX_ERR) begin
            reason = sdei_pkg::RSN_RX_ERROR;
        end else if (DROP_LEVEL) begin
            reason = sdei_pkg::RSN_DROP_LEVEL;
        end else if (DROP_YELLOW) begin
            reason = sdei_pkg::RSN_YELLOW;
        end else begin
            reason_ok = 1'b0;
        end
    end

    //------------------------------------------------------------
    // status sets
    //------------------------------------------------------------
    logic ev;
    logic load_a;
    logic load_b;

    // no cause or reserved port: nothing recorded
    assign ev     = DROP_VALID && reason_ok && (DROP_PORT != sdei_pkg::PORT_RESERVED);
    // a read frees A in the same edge, so an event then lands in A again
    assign load_a = ev && (!a_valid_q || pend_read);
    assign load_b = ev && !load_a && (!b_valid_q || pend_read);

    // set wins over the clear-on-read
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            a_valid_q  <= 1'b0;
            a_port_q   <= sdei_pkg::PORT_RESET;
            a_reason_q <= sdei_pkg::REASON_RESET;
        end else if (load_a) begin
            a_valid_q  <= 1'b1;
            a_port_q   <= DROP_PORT;
            a_reason_q <= reason;
        end else if (pend_read) begin
            a_valid_q  <= 1'b0;
            a_port_q   <= sdei_pkg::PORT_RESET;
            a_reason_q <= sdei_pkg::REASON_RESET;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            b_valid_q  <= 1'b0;
            b_port_q   <= sdei_pkg::PORT_RESET;
            b_reason_q <= sdei_pkg::REASON_RESET;
        end else if (load_b) begin
            b_valid_q  <= 1'b1;
            b_port_q   <= DROP_PORT;
            b_reason_q <= reason;
        end else if (pend_read) begin
            b_valid_q  <= 1'b0;
            b_port_q   <= sdei_pkg::PORT_RESET;
            b_reason_q <= sdei_pkg::REASON_RESET;
        end
    end

    //------------------------------------------------------------
    // interrupt
    //------------------------------------------------------------
    assign IRQ = (a_valid_q || b_valid_q) && !mask_q;

endmodule
`default_nettype wire

//--- verif/sdei_host.sv
// Purpose: host processor model issuing apb transfers; Assumes: any number of wait states
// Notes:   one idle cycle after each transfer, write data inverted once released
`timescale 1ns/100ps
`default_nettype none
module sdei_host (
    input  wire logic        clk,     // clock
    input  wire logic        pready,  // ready
    input  wire logic [31:0] prdata,  // read data
    output logic             psel,    // select
    output logic             penable, // access
    output logic             pwrite,  // direction
    output logic      [17:0] paddr,   // address
    output logic      [31:0] pwdata   // write data
);
    initial {psel, penable, pwrite, paddr, pwdata} = 53'h0;
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        {psel, penable, pwdata} <= {2'b00, ~d};
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- verif/sdei_props.sv
// Purpose: interrupt and pending-field checks; Assumes: zero-wait apb slave
// Notes:   mask mirrored from apb writes, fields judged while a read is in access
`timescale 1ns/100ps
`default_nettype none
module sdei_props (
    input wire logic        CORE_CLK, // clock
    input wire logic        RST,      // reset
    input wire logic        PSEL,     // select
    input wire logic        PENABLE,  // access
    input wire logic        PWRITE,   // direction
    input wire logic [17:0] PADDR,    // address
    input wire logic [31:0] PWDATA,   // write data
    input wire logic [31:0] PRDATA,   // read data
    input wire logic        IRQ       // interrupt
);
    wire  rd_p = PSEL && PENABLE && !PWRITE && PADDR == sdei_pkg::PEND_ADDR;
    wire  wr_m = PSEL && PENABLE && PWRITE && PADDR == sdei_pkg::MASK_ADDR;
    logic mask_q;
    always_ff @(posedge CORE_CLK) mask_q <= RST ? 1'b1 : (wr_m ? PWDATA[0] : mask_q);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_mask_blk; mask_q |-> !IRQ; endproperty
    a_mask_blk: assert property (p_mask_blk) else $error("irq while masked");
    property p_irq_on; rd_p && PRDATA[0] && !mask_q |-> IRQ; endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");
    property p_irq_hold; IRQ && !rd_p && !wr_m |=> IRQ; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq fell early");
    property p_b_after_a; rd_p && PRDATA[7] |-> PRDATA[0]; endproperty
    a_b_after_a: assert property (p_b_after_a) else $error("set b before a");
    property p_a_clean; rd_p && !PRDATA[0] |-> PRDATA[6:1] == 6'h00; endproperty
    a_a_clean: assert property (p_a_clean) else $error("set a stale");
    property p_b_clean; rd_p && !PRDATA[7] |-> PRDATA[13:8] == 6'h00; endproperty
    a_b_clean: assert property (p_b_clean) else $error("set b stale");
    property p_port_ok; rd_p |-> PRDATA[2:1] != 2'h3 && PRDATA[9:8] != 2'h3; endproperty
    a_port_ok: assert property (p_port_ok) else $error("reserved port");
    property p_rsn_ok; rd_p && PRDATA[7] |-> PRDATA[13:10] inside {[4'h0:4'h6], 4'h9}; endproperty
    a_rsn_ok: assert property (p_rsn_ok) else $error("reserved reason");
endmodule
bind sdei_top sdei_props chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .IRQ(IRQ));
`default_nettype wire

//--- verif/testbench.sv
// Purpose: directed bench for the drop event block; Assumes: drops are one-cycle pulses
// Notes:   irq sampled on falling edges, clear of the launch edges
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, rst = 1'b1, dv = 1'b0, ps, pe, pw, rdy, err, irq, irq_s, err_s;
    logic [1:0]  dp = 2'h0;
    logic [7:0]  cz = 8'h00;
    logic [17:0] pa;
    logic [31:0] wd, rdt, q;
    logic [3:0]  code [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    int          miscompares = 0, n_tests = 0;
    sdei_top dut_u (.CORE_CLK(clk), .RST(rst), .PSEL(ps), .PENABLE(pe), .PWRITE(pw), .PADDR(pa),
        .PWDATA(wd), .PRDATA(rdt), .PREADY(rdy), .PSLVERR(err), .DROP_VALID(dv), .DROP_PORT(dp),
        .DROP_BCAST_LVL(cz[0]), .DROP_RED(cz[1]), .DROP_NO_BUF(cz[2]), .DROP_NO_DESC(cz[3]),
        .DROP_NO_DEST(cz[4]), .DROP_RX_ERR(cz[5]), .DROP_LEVEL(cz[6]), .DROP_YELLOW(cz[7]),
        .IRQ(irq));
    sdei_host host_u (.clk(clk), .pready(rdy), .prdata(rdt), .psel(ps), .penable(pe),
        .pwrite(pw), .paddr(pa), .pwdata(wd));
    initial forever #50 clk = ~clk;
    always @(negedge clk) irq_s <= irq;
    // error flag only means something at the completing access edge
    always @(posedge clk) if (ps && pe) err_s <= err;
    initial begin
        #100000 miscompares++;
        end_sim();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] e, input string nm);
        host_u.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task automatic drop(input int c, input logic [1:0] p);
        {dv, dp, cz} <= {1'b1, p, 8'(1 << c)};
        @(posedge clk) {dv, cz} <= 9'h000;
        @(posedge clk);
    endtask
    task automatic end_sim;
        $display("n_tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(sdei_pkg::MASK_ADDR, 32'h1, "mask");
        chk("slverr_ok", 32'h0, 32'(err_s));
        rd(sdei_pkg::PEND_ADDR, 32'h0, "pend");
        rd(18'h00010, 32'h0, "unmapped");
        chk("slverr", 32'h1, 32'(err_s));
        // masked: status still records every cause and port
        for (int i = 0; i < 8; i++) begin
            drop(i, 2'(i % 3));
            chk("masked", 32'h0, 32'(irq_s));
            rd(sdei_pkg::PEND_ADDR, 32'({code[i], 2'(i % 3), 1'b1}), "rsn");
        end
        host_u.xfer(1'b1, sdei_pkg::MASK_ADDR, 32'h0, q);
        drop(1, 2'h1);
        chk("irq_on", 32'h1, 32'(irq_s));
        host_u.xfer(1'b1, sdei_pkg::MASK_ADDR, 32'h1, q);
        chk("remask", 32'h0, 32'(irq_s));
        host_u.xfer(1'b1, sdei_pkg::MASK_ADDR, 32'h0, q);
        chk("unmask", 32'h1, 32'(irq_s));
        drop(7, 2'h2);
        drop(2, 2'h0);
        rd(sdei_pkg::PEND_ADDR, 32'h268b, "two_sets");
        drop(0, 2'h3);
        rd(sdei_pkg::PEND_ADDR, 32'h0, "cleared");
        chk("irq_off", 32'h0, 32'(irq_s));
        end_sim();
    end
endmodule
`default_nettype wire
